// file: design/dwss_pkg.sv
// package: constants shared by both ends of the two-wire wiper link
package dwss_pkg;
  // slave address layout: upper nibble is type id, lower nibble from address pins
  localparam logic [3:0] DWSS_TYPE_ID = 4'hA; // arbitrary value
  localparam int DWSS_BYTE_BITS = 8;
  localparam int DWSS_TAP_BITS = 6;
  localparam int DWSS_TAPS = 64;
  localparam int DWSS_NUM_WIPERS = 2;
  localparam int DWSS_NUM_DREGS = 4;
  // command byte fields
  localparam int DWSS_OP_HI = 7;
  localparam int DWSS_OP_LO = 4;
  localparam int DWSS_WSEL_BIT = 2;
  localparam int DWSS_RSEL_HI = 1;
  localparam int DWSS_RSEL_LO = 0;
  // instruction codes
  localparam logic [3:0] DWSS_OP_RD_WPR = 4'h9;
  localparam logic [3:0] DWSS_OP_WR_WPR = 4'hA;
  localparam logic [3:0] DWSS_OP_RD_DR = 4'hB;
  localparam logic [3:0] DWSS_OP_WR_DR = 4'hC;
  localparam logic [3:0] DWSS_OP_DR2W = 4'hD;
  localparam logic [3:0] DWSS_OP_W2DR = 4'hE;
  localparam logic [3:0] DWSS_OP_GDR2W = 4'h1;
  localparam logic [3:0] DWSS_OP_GW2DR = 4'h8;
  localparam logic [3:0] DWSS_OP_INCDEC = 4'h2;
  // nonvolatile busy time and link clock divider
  localparam int DWSS_NVW_US = 5000;
  localparam int DWSS_CLK_MHZ = 100;
  localparam int DWSS_NVW_CYC = DWSS_NVW_US * DWSS_CLK_MHZ;
  localparam int DWSS_HALF_DIV = 4;
  localparam int DWSS_FIFO_DEPTH = 8;
  localparam logic [3:0] DWSS_BIT_LAST = 4'h7;
  localparam logic [3:0] DWSS_BIT_ACK = 4'h8;
endpackage : dwss_pkg

// file: design/dwss_if.sv
// interface: the shared two-wire link between master and wiper slave
`timescale 1ns/1ns
interface dwss_if;
  logic scl_drv;
  logic sda_m_oe;
  logic sda_s_oe;
  logic sda;
  // open-drain wire: low while either side pulls
  assign sda = !(sda_m_oe || sda_s_oe);
  modport master (output scl_drv, output sda_m_oe, input sda);
  modport slave (input scl_drv, output sda_s_oe, input sda);
endinterface : dwss_if

// file: design/dwss_fifo.sv
// module: small valid/ready FIFO for the master's request stream
`timescale 1ns/1ns
module dwss_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_ff;
  logic [AW:0] rp_ff;
  logic full;
  logic empty;
  assign empty = (wp_ff == rp_ff);
  assign full = (wp_ff[AW-1:0] == rp_ff[AW-1:0]) && (wp_ff[AW] != rp_ff[AW]);
  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out = mem[rp_ff[AW-1:0]];
  // pointers carry an extra wrap bit so full and empty are exact
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else if (clk_en_in) begin
      if (wr_valid_in && !full) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (rd_ready_in && !empty) begin
        rp_ff <= rp_ff + 1'b1;
      end
    end
  end
  // storage has no reset, only written data is ever read
  always_ff @(posedge ref_clk_in) begin
    if (clk_en_in && wr_valid_in && !full) begin
      mem[wp_ff[AW-1:0]] <= wr_data_in;
    end
  end
endmodule : dwss_fifo

// file: design/dwss_master.sv
// module: link master, runs queued commands and makes the link clock
`timescale 1ns/1ns
module dwss_master
  import dwss_pkg::*;
#(
  parameter int FIFO_DEPTH = DWSS_FIFO_DEPTH
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  dwss_if.master link,
  input wire logic [3:0] req_addr_in,
  input wire logic [7:0] req_cmd_in,
  input wire logic [7:0] req_data_in,
  input wire logic req_has_data_in,
  input wire logic req_read_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  output logic [7:0] rsp_data_out,
  output logic rsp_nack_out,
  output logic rsp_valid_out,
  output logic busy_out
);
  typedef enum logic [5:0] {
    DWSS_M_IDLE = 6'h01, DWSS_M_START = 6'h02, DWSS_M_BIT = 6'h04,
    DWSS_M_ACK = 6'h08, DWSS_M_STOP = 6'h10, DWSS_M_DONE = 6'h20
  } dwss_mst_e;
  typedef struct packed {
    dwss_mst_e st;
    logic [2:0] phase;  // quarter steps of one bit time
    logic [3:0] bitn;
    logic [1:0] byten;
    logic [7:0] sh;
    logic [7:0] rx;
    logic nack;
    logic scl;
    logic sda_oe;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_nack;
    logic sda_s1;
    logic sda_s2;
    logic [3:0] div;  // ref cycles within one quarter step
    logic busy;
  } dwss_mst_s;
  dwss_mst_s q_ff;
  dwss_mst_s nxt_q;
  logic [21:0] f_out;
  logic tick;
  logic f_valid;
  logic f_pop;
  logic [1:0] nbytes;
  logic [7:0] cur;
  dwss_fifo #(.WIDTH(22), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
    .wr_data_in({req_read_in, req_has_data_in, req_addr_in, req_cmd_in, req_data_in}),
    .wr_valid_in(req_valid_in), .wr_ready_out(req_ready_out),
    .rd_data_out(f_out), .rd_valid_out(f_valid), .rd_ready_in(f_pop)
  );
  assign nbytes = f_out[20] ? 2'd2 : 2'd1;
  // quarter steps last several ref cycles so the slave's sync and answer fit in
  assign tick = (q_ff.div == 4'(DWSS_HALF_DIV - 1));
  // byte order: address, command, then optional data
  always_comb begin
    case (q_ff.byten)
      2'd0: cur = {DWSS_TYPE_ID, f_out[19:16]};
      2'd1: cur = f_out[15:8];
      default: cur = f_out[7:0];
    endcase
  end
  // bit sequencer: scl rises at phase 2 and falls at phase 3, sda moves at phase 0
  always_comb begin
    nxt_q = q_ff;
    nxt_q.sda_s1 = link.sda;
    nxt_q.sda_s2 = q_ff.sda_s1;
    nxt_q.rsp_valid = 1'b0;
    f_pop = 1'b0;
    nxt_q.phase = q_ff.phase + 3'd1;
    case (q_ff.st)
      DWSS_M_IDLE: begin
        nxt_q.phase = '0;
        nxt_q.scl = 1'b1;
        nxt_q.sda_oe = 1'b0;
        if (f_valid) begin
          nxt_q.st = DWSS_M_START;
          nxt_q.byten = '0;
          nxt_q.nack = 1'b0;
        end
      end
      DWSS_M_START: begin
        if (q_ff.phase == 3'd1) nxt_q.sda_oe = 1'b1;
        if (q_ff.phase == 3'd3) begin
          nxt_q.scl = 1'b0;
          nxt_q.st = DWSS_M_BIT;
          nxt_q.phase = '0;
          nxt_q.bitn = '0;
          nxt_q.sh = cur;
        end
      end
      DWSS_M_BIT: begin
        // data bytes of a read come from the slave, so the master lets go
        if (q_ff.phase == 3'd0) begin
          nxt_q.sda_oe = (q_ff.byten == 2'd2 && f_out[21]) ? 1'b0 : !q_ff.sh[7];
        end
        if (q_ff.phase == 3'd2) nxt_q.scl = 1'b1;
        if (q_ff.phase == 3'd3) begin
          nxt_q.rx = {q_ff.rx[6:0], q_ff.sda_s2};
          nxt_q.sh = {q_ff.sh[6:0], 1'b0};
          nxt_q.scl = 1'b0;
          nxt_q.phase = '0;
          nxt_q.bitn = q_ff.bitn + 4'd1;
          if (q_ff.bitn == DWSS_BIT_LAST) nxt_q.st = DWSS_M_ACK;
        end
      end
      DWSS_M_ACK: begin
        // ninth pulse: master acks nothing on a read, releases otherwise
        if (q_ff.phase == 3'd0) nxt_q.sda_oe = 1'b0;
        if (q_ff.phase == 3'd2) nxt_q.scl = 1'b1;
        if (q_ff.phase == 3'd3) begin
          nxt_q.scl = 1'b0;
          nxt_q.phase = '0;
          nxt_q.bitn = '0;
          nxt_q.byten = q_ff.byten + 2'd1;
          if (q_ff.byten == 2'd2 && f_out[21]) begin
            nxt_q.rsp_data = q_ff.rx;
          end else if (q_ff.sda_s2) begin
            nxt_q.nack = 1'b1;
          end
          if (q_ff.byten == nbytes || (q_ff.sda_s2 && !(q_ff.byten == 2'd2 && f_out[21]))) begin
            nxt_q.st = DWSS_M_STOP;
          end else begin
            nxt_q.st = DWSS_M_BIT;
            nxt_q.sh = (q_ff.byten == 2'd0) ? f_out[15:8] : f_out[7:0];
          end
        end
      end
      DWSS_M_STOP: begin
        if (q_ff.phase == 3'd0) nxt_q.sda_oe = 1'b1;
        if (q_ff.phase == 3'd2) nxt_q.scl = 1'b1;
        if (q_ff.phase == 3'd3) nxt_q.sda_oe = 1'b0;
        if (q_ff.phase == 3'd5) nxt_q.st = DWSS_M_DONE;
      end
      DWSS_M_DONE: begin
        f_pop = 1'b1;
        nxt_q.rsp_valid = 1'b1;
        nxt_q.rsp_nack = q_ff.nack;
        nxt_q.st = DWSS_M_IDLE;
      end
      default: nxt_q.st = DWSS_M_IDLE;
    endcase
    // between ticks only the sync flops, the divider and the response strobe move
    if (!tick) begin
      nxt_q = q_ff;
      nxt_q.sda_s1 = link.sda;
      nxt_q.sda_s2 = q_ff.sda_s1;
      nxt_q.rsp_valid = 1'b0;
      f_pop = 1'b0;
    end
    nxt_q.div = tick ? 4'h0 : q_ff.div + 4'd1;
    nxt_q.busy = (nxt_q.st != DWSS_M_IDLE);
  end
  // one register for all state; frozen while the enable is low
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_ff <= '{st: DWSS_M_IDLE, scl: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1, default: '0};
    end else if (clk_en_in) begin
      q_ff <= nxt_q;
    end
  end
  assign link.scl_drv = q_ff.scl;
  assign link.sda_m_oe = q_ff.sda_oe;
  assign rsp_data_out = q_ff.rsp_data;
  assign rsp_nack_out = q_ff.rsp_nack;
  assign rsp_valid_out = q_ff.rsp_valid;
  assign busy_out = q_ff.busy;
endmodule : dwss_master

// file: design/dwss_slave.sv
// module: wiper slave, two-wire receiver plus wiper and data registers
// How it works
// - master starts transfers and drives the clock
// - data changes only while clock low
// - start condition precedes commands; ignore otherwise
// - watch lines always, start restarts anywhere
// - master ends each exchange with stop
// - transmitter releases data after eight bits
// - ninth pulse: receiver pulls data low; the master as receiver of a read byte releases it instead
// - ack matching slave address after start
// - ack the command byte
// - ack a following data byte
// - address pins set low address nibble
// - position register plus four data registers
// - low six bits pick one tap
// - only one tap switch on at once
// - position loaded directly or from data register
// - position copied into any data register
// - host reads and writes all registers
// - data pin open drain, only pulls low
// - all four address bits must match
// - command: opcode, wiper bit, register select
// - no address ack during nonvolatile write
// - step wiper up or down per pulse
`timescale 1ns/1ns
module dwss_slave
  import dwss_pkg::*;
#(
  parameter int NVW_CYC = DWSS_NVW_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  dwss_if.slave link,
  input wire logic [3:0] addr_select_pins_in,
  output logic [DWSS_TAPS-1:0] tap_on_w0_out,
  output logic [DWSS_TAPS-1:0] tap_on_w1_out,
  output logic nv_busy_out
);
  typedef enum logic [4:0] {
    DWSS_S_IDLE = 5'h01, DWSS_S_ADDR = 5'h02, DWSS_S_CMD = 5'h04,
    DWSS_S_DATA = 5'h08, DWSS_S_STEP = 5'h10
  } dwss_slv_e;
  typedef struct packed {
    dwss_slv_e st;
    logic [2:0] scl_s;  // two-stage sync plus history
    logic [2:0] sda_s;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] cmd;
    logic ack_oe;
    logic drive;        // slave transmits this byte
    logic [DWSS_NUM_WIPERS-1:0][7:0] wpr;
    logic [DWSS_NUM_WIPERS-1:0][DWSS_NUM_DREGS-1:0][7:0] dreg;
    logic [22:0] nv_cnt;
    logic nv_busy;
    logic armed;        // a rise was seen since the start
    logic [3:0] pin_s1; // address pins, two-stage sync
    logic [3:0] pin_s2;
    logic [DWSS_TAPS-1:0] tap0;
    logic [DWSS_TAPS-1:0] tap1;
  } dwss_slv_s;
  dwss_slv_s q_ff;
  dwss_slv_s nxt_q;
  logic scl_rise;
  logic scl_fall;
  logic scl_hi;
  logic sda_v;
  logic start_c;
  logic stop_c;
  logic wsel;
  logic [1:0] rsel;
  logic [3:0] op;
  logic [7:0] rd_byte;
  // one-hot tap decode of the low six position bits only
  function automatic logic [DWSS_TAPS-1:0] tap_dec(input logic [7:0] pos);
    tap_dec = '0;
    tap_dec[pos[DWSS_TAP_BITS-1:0]] = 1'b1;
  endfunction : tap_dec
  // edges seen only on stages two and three, never the first flop
  assign scl_hi = q_ff.scl_s[1];
  assign sda_v = q_ff.sda_s[1];
  assign scl_rise = q_ff.scl_s[1] && !q_ff.scl_s[2];
  assign scl_fall = !q_ff.scl_s[1] && q_ff.scl_s[2];
  assign start_c = scl_hi && q_ff.scl_s[2] && !sda_v && q_ff.sda_s[2];
  assign stop_c = scl_hi && q_ff.scl_s[2] && sda_v && !q_ff.sda_s[2];
  assign op = q_ff.cmd[DWSS_OP_HI:DWSS_OP_LO];
  assign wsel = q_ff.cmd[DWSS_WSEL_BIT];
  assign rsel = q_ff.cmd[DWSS_RSEL_HI:DWSS_RSEL_LO];
  assign rd_byte = (op == DWSS_OP_RD_WPR) ? q_ff.wpr[wsel] : q_ff.dreg[wsel][rsel];
  // receiver, ack and register actions
  always_comb begin
    nxt_q = q_ff;
    nxt_q.scl_s = {q_ff.scl_s[1:0], link.scl_drv};
    nxt_q.sda_s = {q_ff.sda_s[1:0], link.sda};
    nxt_q.pin_s1 = addr_select_pins_in;
    nxt_q.pin_s2 = q_ff.pin_s1;
    if (q_ff.nv_cnt != '0) nxt_q.nv_cnt = q_ff.nv_cnt - 23'd1;
    if (start_c) begin
      nxt_q.st = DWSS_S_ADDR;
      nxt_q.bitn = '0;
      nxt_q.armed = 1'b0;
      nxt_q.ack_oe = 1'b0;
      nxt_q.drive = 1'b0;
    end else if (stop_c) begin
      nxt_q.st = DWSS_S_IDLE;
      nxt_q.ack_oe = 1'b0;
      nxt_q.drive = 1'b0;
    end else begin
      case (q_ff.st)
        DWSS_S_IDLE: nxt_q.ack_oe = 1'b0;
        DWSS_S_STEP: begin
          // each high pulse moves the wiper one segment, clamped at the ends
          if (scl_rise) begin
            if (sda_v && q_ff.wpr[wsel][5:0] != 6'h3F) begin
              nxt_q.wpr[wsel] = q_ff.wpr[wsel] + 8'h01;
            end else if (!sda_v && q_ff.wpr[wsel][5:0] != 6'h00) begin
              nxt_q.wpr[wsel] = q_ff.wpr[wsel] - 8'h01;
            end
          end
          if (scl_fall) nxt_q.ack_oe = 1'b0;
        end
        default: begin
          // the fall that ends a start has no bit before it, so it is skipped
          if (scl_rise) nxt_q.armed = 1'b1;
          if (scl_rise && q_ff.bitn < DWSS_BIT_ACK && !q_ff.drive) begin
            nxt_q.sh = {q_ff.sh[6:0], sda_v};
          end
          if (scl_fall && q_ff.armed) begin
            nxt_q.bitn = q_ff.bitn + 4'd1;
            nxt_q.ack_oe = 1'b0;
            if (q_ff.drive && q_ff.bitn < DWSS_BIT_LAST) begin
              nxt_q.ack_oe = !q_ff.sh[7];
              nxt_q.sh = {q_ff.sh[6:0], 1'b1};
            end
            if (q_ff.bitn == DWSS_BIT_LAST && !q_ff.drive) begin
              case (q_ff.st)
                DWSS_S_ADDR: begin
                  if (q_ff.sh == {DWSS_TYPE_ID, q_ff.pin_s2}
                      && q_ff.nv_cnt == '0) begin
                    nxt_q.ack_oe = 1'b1;
                  end else begin
                    nxt_q.st = DWSS_S_IDLE;
                  end
                end
                DWSS_S_CMD: begin
                  nxt_q.ack_oe = 1'b1;
                  nxt_q.cmd = q_ff.sh;
                end
                default: begin
                  nxt_q.ack_oe = 1'b1;
                  if (op == DWSS_OP_WR_WPR) nxt_q.wpr[wsel] = q_ff.sh;
                  if (op == DWSS_OP_WR_DR) begin
                    nxt_q.dreg[wsel][rsel] = q_ff.sh;
                    nxt_q.nv_cnt = 23'(NVW_CYC);
                  end
                end
              endcase
            end
            if (q_ff.bitn == DWSS_BIT_ACK) begin
              nxt_q.bitn = '0;
              nxt_q.drive = 1'b0;
              if (q_ff.st == DWSS_S_ADDR) nxt_q.st = DWSS_S_CMD;
              if (q_ff.st == DWSS_S_CMD) begin
                nxt_q.st = DWSS_S_DATA;
                case (op)
                  DWSS_OP_INCDEC: nxt_q.st = DWSS_S_STEP;
                  DWSS_OP_RD_WPR, DWSS_OP_RD_DR: begin
                    nxt_q.drive = 1'b1;
                    nxt_q.sh = {rd_byte[6:0], 1'b1};
                    nxt_q.ack_oe = !rd_byte[7];
                  end
                  DWSS_OP_DR2W: nxt_q.wpr[wsel] = q_ff.dreg[wsel][rsel];
                  DWSS_OP_W2DR: begin
                    nxt_q.dreg[wsel][rsel] = q_ff.wpr[wsel];
                    nxt_q.nv_cnt = 23'(NVW_CYC);
                  end
                  DWSS_OP_GDR2W: begin
                    for (int w = 0; w < DWSS_NUM_WIPERS; w++) begin
                      nxt_q.wpr[w] = q_ff.dreg[w][rsel];
                    end
                  end
                  DWSS_OP_GW2DR: begin
                    for (int w = 0; w < DWSS_NUM_WIPERS; w++) begin
                      nxt_q.dreg[w][rsel] = q_ff.wpr[w];
                    end
                    nxt_q.nv_cnt = 23'(NVW_CYC);
                  end
                  default: nxt_q.st = DWSS_S_DATA;
                endcase
              end
              if (q_ff.st == DWSS_S_DATA) nxt_q.st = DWSS_S_IDLE;
            end
          end
        end
      endcase
    end
    nxt_q.tap0 = tap_dec(nxt_q.wpr[0]);
    nxt_q.tap1 = tap_dec(nxt_q.wpr[1]);
    nxt_q.nv_busy = (nxt_q.nv_cnt != '0);
  end
  // registers start at tap zero; frozen while the enable is low
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_ff <= '{st: DWSS_S_IDLE, scl_s: 3'h7, sda_s: 3'h7, tap0: 64'h1, tap1: 64'h1,
                default: '0};
    end else if (clk_en_in) begin
      q_ff <= nxt_q;
    end
  end
  // open drain: only the enable is driven, level comes from the wire
  assign link.sda_s_oe = q_ff.ack_oe;
  assign tap_on_w0_out = q_ff.tap0;
  assign tap_on_w1_out = q_ff.tap1;
  assign nv_busy_out = q_ff.nv_busy;
endmodule : dwss_slave

// file: sim/dwss_assertions.sv
// checker: protocol timing on the shared two-wire link
`timescale 1ns/1ns
module dwss_assertions (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic scl_drv,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic sda
);
  // ====================
  // link tracker
  typedef struct packed {
    logic scl_q;
    logic sda_q;
    logic idle;
    logic [3:0] bit_n;
    logic [1:0] byte_n;
  } dwss_trk_s;
  dwss_trk_s st_ff;
  dwss_trk_s nxt_st;
  logic start_ev;
  logic stop_ev;
  logic rise_ev;
  logic ninth;
  // edges from last-cycle copies, so no sampled functions outside properties
  assign start_ev = st_ff.scl_q && scl_drv && st_ff.sda_q && !sda;
  assign stop_ev = st_ff.scl_q && scl_drv && !st_ff.sda_q && sda;
  assign rise_ev = !st_ff.scl_q && scl_drv;
  assign ninth = rise_ev && (st_ff.bit_n == 4'h8);
  // bit and byte position; byte count saturates, only the first two matter
  always_comb begin
    nxt_st = st_ff;
    nxt_st.scl_q = scl_drv;
    nxt_st.sda_q = sda;
    if (start_ev) begin
      nxt_st.idle = 1'b0;
      nxt_st.bit_n = 4'h0;
      nxt_st.byte_n = 2'h0;
    end else if (stop_ev) begin
      nxt_st.idle = 1'b1;
    end else if (ninth) begin
      nxt_st.bit_n = 4'h0;
      nxt_st.byte_n = (st_ff.byte_n == 2'h3) ? 2'h3 : st_ff.byte_n + 2'h1;
    end else if (rise_ev) begin
      nxt_st.bit_n = st_ff.bit_n + 4'h1;
    end
  end
  // register the tracker
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= '{1'b1, 1'b1, 1'b1, 4'h0, 2'h0};
    end else begin
      st_ff <= nxt_st;
    end
  end
  // ====================
  // properties
  default clocking dwss_cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  a_slave_data_low: assert property ($changed(sda_s_oe) |-> !scl_drv)
    else $error("slave data moved while clock high");
  a_start_by_master: assert property (start_ev |-> sda_m_oe && !sda_s_oe)
    else $error("start not made by master");
  a_idle_clock_high: assert property (st_ff.idle |-> scl_drv)
    else $error("clock low between frames");
  a_idle_slave_quiet: assert property (st_ff.idle |-> !sda_s_oe)
    else $error("slave pulls data outside a frame");
  a_master_releases: assert property (ninth && st_ff.byte_n < 2'h2 |-> !sda_m_oe)
    else $error("master holds data in ack slot");
  a_slave_rx_quiet: assert property (
      rise_ev && st_ff.bit_n < 4'h8 && st_ff.byte_n < 2'h2 |-> !sda_s_oe)
    else $error("slave pulls data during master byte");
  a_slave_release_bound: assert property ($rose(sda_s_oe) |-> ##[1:300] !sda_s_oe)
    else $error("slave never released data");
  a_clock_low_bound: assert property ($fell(scl_drv) |-> ##[1:64] scl_drv)
    else $error("link clock stuck low");
  c_start: cover property (start_ev);
  c_cmd_ack: cover property (ninth && st_ff.byte_n == 2'h1 && sda_s_oe);
  c_stop: cover property (stop_ev);
endmodule : dwss_assertions

// file: sim/dwss_bench.sv
// bench: both link ends joined, driven through the master request port
`timescale 1ns/1ns
module dwss_bench;
  import dwss_pkg::*;
  // ====================
  // signals and bench model
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic run_en = 1'b1;
  logic [3:0] pins = 4'h0;
  logic [3:0] r_addr = 4'h0;
  logic [7:0] r_cmd = 8'h00;
  logic [7:0] r_data = 8'h00;
  logic r_hd = 1'b0;
  logic r_rd = 1'b0;
  logic r_valid = 1'b0;
  logic saw_full = 1'b0;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic [7:0] sh = 8'h00;
  logic r_ready;
  logic rs_nack;
  logic rs_valid;
  logic nv_busy;
  logic [7:0] rs_data;
  logic [63:0] tap0;
  logic [63:0] tap1;
  logic [3:0] op;
  logic [7:0] m_w [2];
  logic [7:0] m_d [2][4];
  logic [9:0] rsp_q [$];
  logic [9:0] exp_q [$];
  logic m_busy;
  logic [3:0] ops [9] = '{DWSS_OP_RD_WPR, DWSS_OP_WR_WPR, DWSS_OP_RD_DR, DWSS_OP_WR_DR,
    DWSS_OP_DR2W, DWSS_OP_W2DR, DWSS_OP_GDR2W, DWSS_OP_GW2DR, DWSS_OP_INCDEC};
  int nb = 8;
  int n_fail = 0;
  int comparisons = 0;
  // ====================
  // ends of the link and checker
  dwss_if u_dwss_if();
  dwss_master u_dwss_master (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .clk_en_in(run_en),
    .link(u_dwss_if), .req_addr_in(r_addr), .req_cmd_in(r_cmd), .req_data_in(r_data),
    .req_has_data_in(r_hd), .req_read_in(r_rd), .req_valid_in(r_valid),
    .req_ready_out(r_ready), .rsp_data_out(rs_data), .rsp_nack_out(rs_nack),
    .rsp_valid_out(rs_valid), .busy_out(m_busy));
  dwss_slave #(.NVW_CYC(1000)) u_dwss_slave (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .clk_en_in(run_en), .link(u_dwss_if), .addr_select_pins_in(pins),
    .tap_on_w0_out(tap0), .tap_on_w1_out(tap1), .nv_busy_out(nv_busy));
  dwss_assertions u_dwss_assertions (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .scl_drv(u_dwss_if.scl_drv), .sda_m_oe(u_dwss_if.sda_m_oe),
    .sda_s_oe(u_dwss_if.sda_s_oe), .sda(u_dwss_if.sda));
  // 100 MHz reference
  always #5 ref_clk_in = ~ref_clk_in;
  // responses, queue refusals and the first byte after each start
  always @(posedge ref_clk_in) begin
    scl_q <= u_dwss_if.scl_drv;
    sda_q <= u_dwss_if.sda;
    if (rs_valid === 1'b1) rsp_q.push_back({rs_nack, 1'b0, rs_data});
    if (r_valid === 1'b1 && r_ready === 1'b0) saw_full <= 1'b1;
    if (scl_q && u_dwss_if.scl_drv && sda_q && !u_dwss_if.sda) begin
      nb <= 0;
    end else if (!scl_q && u_dwss_if.scl_drv && nb < 8) begin
      sh <= {sh[6:0], u_dwss_if.sda};
      nb <= nb + 1;
    end
  end
  // ====================
  // tasks
  task automatic check(input string nm, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : check
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  task automatic clear_model();
    for (int i = 0; i < 2; i++) begin
      m_w[i] = 8'h00;
      for (int j = 0; j < 4; j++) m_d[i][j] = 8'h00;
    end
  endtask : clear_model
  // register moves as the instruction set defines them
  task automatic apply(input logic [7:0] c, input logic [7:0] d);
    for (int i = 0; i < 2; i++) begin
      if (c[7:4] == DWSS_OP_GDR2W) m_w[i] = m_d[i][c[1:0]];
      if (c[7:4] == DWSS_OP_GW2DR) m_d[i][c[1:0]] = m_w[i];
    end
    case (c[7:4])
      DWSS_OP_WR_WPR: m_w[c[2]] = d;
      DWSS_OP_WR_DR: m_d[c[2]][c[1:0]] = d;
      DWSS_OP_DR2W: m_w[c[2]] = m_d[c[2]][c[1:0]];
      DWSS_OP_W2DR: m_d[c[2]][c[1:0]] = m_w[c[2]];
      // with no data byte the only pulse is the stop's, data low: one step down
      DWSS_OP_INCDEC: if (m_w[c[2]][5:0] != 6'h00) m_w[c[2]] = m_w[c[2]] - 8'h01;
      default: ;
    endcase
  endtask : apply
  // queue one request; valid stays up so requests can follow back to back
  task automatic issue(input logic [3:0] a, input logic [7:0] c, input logic [7:0] d,
      input logic nk);
    int k;
    logic rd;
    k = 0;
    rd = (c[7:4] == DWSS_OP_RD_WPR) || (c[7:4] == DWSS_OP_RD_DR);
    exp_q.push_back({nk, rd && !nk, (c[7:4] == DWSS_OP_RD_WPR) ? m_w[c[2]] : m_d[c[2]][c[1:0]]});
    if (!nk) apply(c, d);
    r_addr <= a;
    r_cmd <= c;
    r_data <= d;
    r_rd <= rd;
    r_hd <= rd || (c[7:4] == DWSS_OP_WR_WPR) || (c[7:4] == DWSS_OP_WR_DR);
    r_valid <= 1'b1;
    do begin
      @(negedge ref_clk_in);
      k++;
    end while (r_ready !== 1'b1 && k < 3000);
    if (k >= 3000) begin
      n_fail++;
      summarize();
    end
    @(posedge ref_clk_in);
  endtask : issue
  // wait for n answers, compare them in order, then the tap outputs
  task automatic drain(input int n);
    int k;
    logic [9:0] g;
    logic [9:0] e;
    k = 0;
    r_valid <= 1'b0;
    while (rsp_q.size() < n && k < 20000) begin
      @(posedge ref_clk_in);
      k++;
    end
    if (k >= 20000) begin
      n_fail++;
      summarize();
    end
    repeat (4) @(posedge ref_clk_in);
    while (rsp_q.size() > 0 && exp_q.size() > 0) begin
      g = rsp_q.pop_front();
      e = exp_q.pop_front();
      check("nack", 64'(e[9]), 64'(g[9]));
      if (e[8]) check("read", 64'(e[7:0]), 64'(g[7:0]));
    end
    check("taps0", 64'h1 << m_w[0][5:0], tap0);
    check("taps1", 64'h1 << m_w[1][5:0], tap1);
    check("busy", 64'h0, 64'(m_busy));
  endtask : drain
  task automatic settle();
    int k;
    k = 0;
    repeat (8) @(posedge ref_clk_in);
    while (nv_busy !== 1'b0 && k < 5000) begin
      @(posedge ref_clk_in);
      k++;
    end
    if (k >= 5000) begin
      n_fail++;
      summarize();
    end
  endtask : settle
  // ====================
  // scenarios
  initial begin
    void'($urandom(32'hB96B));
    pins <= 4'($urandom());
    clear_model();
    repeat (3) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    // upper position bits are stored whole yet ignored by the tap decode
    issue(pins, {DWSS_OP_WR_WPR, 4'h0}, 8'hFF, 1'b0);
    issue(pins, {DWSS_OP_WR_WPR, 4'h4}, 8'hC0, 1'b0);
    issue(pins, {DWSS_OP_RD_WPR, 4'h0}, 8'h00, 1'b0);
    drain(3);
    check("addr byte", 64'({DWSS_TYPE_ID, pins}), 64'(sh));
    // every instruction once, then a random mix
    for (int i = 0; i < 24; i++) begin
      op = (i < 9) ? ops[i] : ops[$urandom_range(8)];
      issue(pins, {op, 1'b0, 1'($urandom()), 2'($urandom())}, 8'($urandom()), 1'b0);
      drain(1);
      settle();
    end
    // one wrong address bit must go unanswered
    for (int b = 0; b < 4; b++) begin
      issue(pins ^ (4'h1 << b), {DWSS_OP_RD_WPR, 4'h0}, 8'h00, 1'b1);
      drain(1);
    end
    check("addr byte", 64'({DWSS_TYPE_ID, pins ^ 4'h8}), 64'(sh));
    // access right behind a register write lands in the busy window
    issue(pins, {DWSS_OP_WR_DR, 4'h5}, 8'h3C, 1'b0);
    issue(pins, {DWSS_OP_RD_DR, 4'h5}, 8'h00, 1'b1);
    drain(2);
    check("nv busy", 64'h1, 64'(nv_busy));
    settle();
    issue(pins, {DWSS_OP_RD_DR, 4'h5}, 8'h00, 1'b0);
    drain(1);
    // back-to-back reads fill the request queue until it refuses
    for (int i = 0; i < 12; i++) issue(pins, {DWSS_OP_RD_WPR, 1'b0, i[0], 2'h0}, 8'h00, 1'b0);
    drain(12);
    check("queue full seen", 64'h1, 64'(saw_full));
    // a short freeze in mid-transfer only stretches it
    issue(pins, {DWSS_OP_RD_WPR, 4'h4}, 8'h00, 1'b0);
    r_valid <= 1'b0;
    repeat (100) @(posedge ref_clk_in);
    run_en <= 1'b0;
    repeat (20) @(posedge ref_clk_in);
    run_en <= 1'b1;
    drain(1);
    // reset in mid-run returns wipers to tap 0 and clears the registers
    rst_in <= 1'b1;
    @(posedge ref_clk_in);
    rst_in <= 1'b0;
    clear_model();
    issue(pins, {DWSS_OP_RD_DR, 4'h5}, 8'h00, 1'b0);
    drain(1);
    summarize();
  end
endmodule : dwss_bench
